// ===== core/srw_supervisor.v
`timescale 1ns/100ps
`include "srw_defs.vh"
module srw_supervisor #(
  parameter [31:0] RST_CYCLES = `SRW_RST_CYCLES,
  parameter [31:0] WD_CYCLES  = `SRW_WD_CYCLES
) (
  input  wire core_clk,
  input  wire rst_n,
  input  wire supply_below_reset_in,
  input  wire supply_below_switch_in,
  input  wire supply_below_min_in,
  input  wire backup_above_supply_in,
  input  wire power_fail_sense_in,
  input  wire manual_reset_n_in,
  input  wire watchdog_kick_in,
  output reg  reset_n_out,
  output reg  reset_od_out,
  output reg  reset_od_oe,
  output reg  power_fail_flag_n,
  output reg  backup_select_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // manual reset sync flops reset to 0; mr_n is forced high only while rst_n is low
  wire [6:0] raw_in;
  wire [6:0] syn;
  assign raw_in = {watchdog_kick_in, manual_reset_n_in, power_fail_sense_in,
                   backup_above_supply_in, supply_below_min_in,
                   supply_below_switch_in, supply_below_reset_in};
  srw_sync #(.W(7), .INIT(1'b0)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (raw_in),
    .q        (syn)
  );
  wire below_rst = syn[0];
  wire below_sw  = syn[1];
  wire below_min = syn[2];
  wire bat_high  = syn[3];
  wire pf_low    = syn[4];
  wire mr_n      = syn[5] | ~rst_n;
  wire kick      = syn[6];

  // ----------------------------------------
  // reset timer
  // ----------------------------------------
  reg  [`SRW_CNT_W-1:0] rst_cnt_ff;
  reg  [`SRW_CNT_W-1:0] wd_cnt_ff;
  reg                   kick_ff;
  reg                   hold_ff;
  reg  [`SRW_CNT_W-1:0] nxt_rst_cnt;
  reg  [`SRW_CNT_W-1:0] nxt_wd_cnt;
  reg                   nxt_hold;
  wire                  wd_fire;
  wire                  kick_edge;
  wire                  cause;

  assign kick_edge = kick ^ kick_ff;
  assign wd_fire   = !hold_ff && (wd_cnt_ff >= WD_CYCLES - 32'h1);
  // level causes hold reset; dips restart the timer
  assign cause     = below_rst | ~mr_n;

  always @* begin
    nxt_rst_cnt = rst_cnt_ff;
    nxt_hold    = hold_ff;
    if (cause || wd_fire) begin
      nxt_hold    = 1'b1;
      nxt_rst_cnt = {`SRW_CNT_W{1'b0}};
    end else if (hold_ff) begin
      if (rst_cnt_ff >= RST_CYCLES - 32'h1) begin
        nxt_hold    = 1'b0;
        nxt_rst_cnt = {`SRW_CNT_W{1'b0}};
      end else begin
        nxt_rst_cnt = rst_cnt_ff + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  // no enable input exists: the watchdog always runs outside reset
  always @* begin
    if (hold_ff || kick_edge || wd_fire) begin
      nxt_wd_cnt = {`SRW_CNT_W{1'b0}};
    end else begin
      nxt_wd_cnt = wd_cnt_ff + 32'h1;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      rst_cnt_ff        <= {`SRW_CNT_W{1'b0}};
      wd_cnt_ff         <= {`SRW_CNT_W{1'b0}};
      kick_ff           <= 1'b0;
      hold_ff           <= 1'b1;
      reset_n_out       <= 1'b0;
      reset_od_out      <= 1'b0;
      reset_od_oe       <= 1'b1;
      power_fail_flag_n <= 1'b0;
      backup_select_out <= 1'b0;
    end else begin
      rst_cnt_ff   <= nxt_rst_cnt;
      wd_cnt_ff    <= nxt_wd_cnt;
      kick_ff      <= kick;
      hold_ff      <= nxt_hold;
      reset_n_out  <= ~nxt_hold;
      reset_od_out <= 1'b0;
      reset_od_oe  <= nxt_hold;
      // comparator path is separate from reset logic
      power_fail_flag_n <= ~(pf_low | below_sw);
      if (below_min || (below_sw && bat_high)) begin
        backup_select_out <= 1'b1;
      end else if (!below_rst) begin
        backup_select_out <= 1'b0;
      end
    end
  end
endmodule // srw_supervisor

// ===== core/srw_defs.vh
// How it works
// - a watchdog timeout drives reset low as one pulse of 200ms
// - reset stays asserted while supply is low, then full timeout after
// - each supply dip asserts reset and restarts the timeout counter
// - a brownout drives reset low at once
// - manual reset low holds reset; 200ms more after it returns high
// - bouncing manual input: any low holds, timeout from the last rise
// - an open manual-reset input reads high and causes no reset
// - kick input static for 1.6sec while counting triggers a reset pulse
// - watchdog counter clears on every kick edge and every reset pulse
// - watchdog counter held at zero during reset, counts after release
// - a static kick input yields a reset pulse every 1.8sec
// - the watchdog can never be disabled
// - open-drain reset follows reset_n_out: driven low during reset, released when idle
// - power-fail flag low while sense input is below its reference
// - supply below switch level forces the power-fail flag low
// - above switch level on power-up the flag follows the comparator
// - backup select when below switch level and backup higher, or <1.75V
// - return to main supply only once supply is above reset threshold
`ifndef SRW_DEFS_VH
`define SRW_DEFS_VH
`define SRW_CLK_HZ        40000000
`define SRW_RST_TIME_MS   200
`define SRW_WD_TIME_MS    1600
`define SRW_RST_CYCLES    ((`SRW_CLK_HZ / 1000) * `SRW_RST_TIME_MS)
`define SRW_WD_CYCLES     ((`SRW_CLK_HZ / 1000) * `SRW_WD_TIME_MS)
`define SRW_CNT_W         32
`endif

// ===== core/srw_sync.v
`timescale 1ns/100ps
// ----------------------------------------
// two-flop synchroniser, vector wide
// ----------------------------------------
module srw_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= {W{INIT}};
      sync_ff <= {W{INIT}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule // srw_sync

// ===== bench/srw_props.sv
`timescale 1ns/100ps
module srw_props (input wire core_clk, rst_n, supply_below_reset_in,
  supply_below_switch_in, supply_below_min_in, backup_above_supply_in,
  power_fail_sense_in, manual_reset_n_in, watchdog_kick_in, reset_n_out,
  reset_od_out, reset_od_oe, power_fail_flag_n, backup_select_out);
  // inputs pass two sync flops, so each cause must be seen for four edges
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_bo; supply_below_reset_in[*4] |-> !reset_n_out; endproperty
  a_bo: assert property (p_bo) else $error("dip without reset");
  property p_mr; !manual_reset_n_in[*4] |-> !reset_n_out; endproperty
  a_mr: assert property (p_mr) else $error("manual without reset");
  property p_hold; $fell(reset_n_out) |=> !reset_n_out[*8]; endproperty
  a_hold: assert property (p_hold) else $error("reset pulse short");
  property p_od; reset_od_oe == !reset_n_out && !reset_od_out; endproperty
  a_od: assert property (p_od) else $error("inverted reset wrong");
  property p_pf; power_fail_sense_in[*4] |-> !power_fail_flag_n; endproperty
  a_pf: assert property (p_pf) else $error("flag not low");
  property p_sw; supply_below_switch_in[*4] |-> !power_fail_flag_n;
  endproperty
  a_sw: assert property (p_sw) else $error("flag not forced");
  property p_bk; supply_below_min_in[*4] |-> backup_select_out; endproperty
  a_bk: assert property (p_bk) else $error("backup not chosen");
  property p_main; !supply_below_reset_in[*4] |-> !backup_select_out;
  endproperty
  a_main: assert property (p_main) else $error("backup kept");
endmodule // srw_props
bind srw_supervisor srw_props u_props (.*);

// ===== bench/srw_cpu_model.sv
`timescale 1ns/100ps
module srw_cpu_model (
  input  wire core_clk,
  input  wire reset_n,
  input  wire kick_en,
  output reg  kick = 1'h0
);
  reg [3:0] cnt_ff = 4'h0;
  // kicks well inside the timeout; silent while held in reset
  always @(posedge core_clk) begin
    cnt_ff <= (reset_n && kick_en) ? cnt_ff + 4'h1 : 4'h0;
    if (cnt_ff == 4'hF) kick <= ~kick;
  end
endmodule // srw_cpu_model

// ===== bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic core_clk = 0, rst_n = 0, kick_en = 0, supply_below_reset_in = 1;
  logic supply_below_switch_in = 1, supply_below_min_in = 1;
  logic backup_above_supply_in = 1, power_fail_sense_in = 1;
  logic manual_reset_n_in = 1;
  wire  watchdog_kick_in, reset_n_out, reset_od_out, reset_od_oe;
  wire  power_fail_flag_n, backup_select_out;
  int   bad_count = 0, comparisons = 0, n;
  always #12.5 core_clk = ~core_clk;
  srw_supervisor #(.RST_CYCLES(20), .WD_CYCLES(100)) DUT (.*);
  srw_cpu_model u_cpu (.core_clk, .reset_n(reset_n_out), .kick_en,
    .kick(watchdog_kick_in));
  task give_verdict;
    $display("comparisons %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic s, input logic e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %0t value %b", $time, s);
    end
  endtask
  task drv(input logic [6:0] v);
    @(posedge core_clk);
    {supply_below_reset_in, supply_below_switch_in, supply_below_min_in,
      backup_above_supply_in, power_fail_sense_in, manual_reset_n_in,
      kick_en} <= v;
  endtask
  task until_rn(input logic v);
    n = 0;
    while (reset_n_out !== v && n < 500) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task t_supply;
    drv(7'h7B); drv(7'h7B); repeat (6) @(negedge core_clk);
    chk(reset_n_out, 1'h0);
    chk(reset_od_oe, 1'h1);
    chk(power_fail_flag_n, 1'h0);
    chk(backup_select_out, 1'h1);
    drv(7'h43); repeat (6) @(negedge core_clk);
    chk(power_fail_flag_n, 1'h1);
    chk(backup_select_out, 1'h1);
    drv(7'h03); until_rn(1'h1);
    chk(n > 19 && n < 27, 1'h1);
    chk(reset_od_oe, 1'h0);
    chk(backup_select_out, 1'h0);
    drv(7'h47); drv(7'h07); until_rn(1'h0); until_rn(1'h1);
    chk(n > 16 && n < 25, 1'h1);
    chk(power_fail_flag_n, 1'h0);
    $display("supply test done");
  endtask
  task t_manual;
    drv(7'h01); repeat (6) @(negedge core_clk);
    chk(reset_n_out, 1'h0);
    drv(7'h03); drv(7'h01); drv(7'h03); until_rn(1'h0); until_rn(1'h1);
    chk(n > 16 && n < 25, 1'h1);
    $display("manual test done");
  endtask
  task t_watchdog;
    drv(7'h02); until_rn(1'h0); until_rn(1'h1);
    chk(n > 19 && n < 23, 1'h1);
    until_rn(1'h0);
    chk(n > 98 && n < 104, 1'h1);
    drv(7'h03); until_rn(1'h1); repeat (300) @(negedge core_clk);
    chk(reset_n_out, 1'h1);
    $display("watchdog test done");
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    t_supply;
    t_manual;
    t_watchdog;
    give_verdict;
  end
  // whole run needs about 650 cycles
  initial begin
    #200000;
    bad_count++;
    give_verdict;
  end
endmodule // tb
